// ===== logic/adc_trigger_cal.sv
// Design decisions made here: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Codes 0,1,2: none, common, level software
// - Code 3 reserved; 4 special; 5-10 primaries
// - 11 logic one, 12-13 timers, 14 special
// - Codes 15-20 pick PWM secondary triggers
// - 21 logic two, 22-23 output compares
// - Codes 24-29 pick PWM current-limit triggers
// - 30 programmable generator, 31 external input
// - Selector in bits 4-0, 7-5 read zero
// - Done flag set by hardware, read only
// - Start bit launches calibration, self-clears
// - Bypass skips power-up calibration of core
// - Differential bit picks calibration input mode
// - Enable gates access to other calibration bits
// - Cores 0-3 packed by byte, gaps zero
// - Shared core same bits in high byte
module adc_trigger_cal
	import adc_ctl_pkg::*;
(
	input  wire logic                 clk_i,
	input  wire logic                 resetn_i,
	input  wire logic                 ce_i,
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [7:0]           wb_adr_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic [31:0]          wb_dat_i,
	output logic [31:0]               wb_dat_o,
	output logic                      wb_ack_o,
	input  wire logic                 pwm_special_i,
	input  wire logic [5:0]           pwm_primary_i,
	input  wire logic                 logic_cell_one_output_i,
	input  wire logic                 timer1_period_i,
	input  wire logic                 timer2_period_i,
	input  wire logic                 pwm_sec_special_i,
	input  wire logic [5:0]           pwm_secondary_i,
	input  wire logic                 logic_cell_two_output_i,
	input  wire logic                 oc1_trigger_i,
	input  wire logic                 oc2_trigger_i,
	input  wire logic [5:0]           pwm_current_limit_i,
	input  wire logic                 programmable_trigger_generator_i,
	input  wire logic                 external_trigger_input_i,
	output logic [NUM_TRIG-1:0]       chan_trigger_o,
	output logic [NUM_CORE-1:0]       cal_active_o,
	output logic [NUM_CORE-1:0]       cal_differential_o,
	output logic                      irq_o
);

	typedef struct packed {
		logic [NUM_TRIG-1:0][SEL_W-1:0]     sel;
		logic [NUM_CORE-1:0]                en;
		logic [NUM_CORE-1:0]                bypass;
		logic [NUM_CORE-1:0]                diff;
		logic [NUM_CORE-1:0]                run;
		logic [NUM_CORE-1:0]                done;
		logic [NUM_CORE-1:0]                powered;
		logic [NUM_CORE-1:0][CAL_CNT_W-1:0] cnt;
		logic [NUM_CORE-1:0]                irq_stat;
		logic [NUM_CORE-1:0]                irq_mask;
		logic                               sw_level;
		logic                               sw_pulse;
		logic                               ext_s1;
		logic                               ext_s2;
		logic                               ack;
		logic [31:0]                        rdata;
		logic [NUM_TRIG-1:0]                trig;
	} state_s;

	state_s      st;
	state_s      next_st;
	logic [31:0] src;
	logic [31:0] rd;
	logic [7:0]  addr;
	logic        req;
	logic        wr;

	function automatic logic [7:0] trig_off(input int g);
		trig_off = OFF_TRIG0 + 8'(g * TRIG_STRIDE);
	endfunction

	function automatic logic [7:0] core_off(input int k);
		if (k < 2) begin
			core_off = OFF_CAL01;
		end else if (k < 4) begin
			core_off = OFF_CAL23;
		end else begin
			core_off = OFF_CAL_SHR;
		end
	endfunction

	function automatic int core_lane(input int k);
		core_lane = (k == SHR_CORE) ? 1 : k % 2;
	endfunction

	// Status byte of one core, gated by its enable
	function automatic logic [7:0] cal_byte(input logic en,
		input logic bypass, input logic diff, input logic run,
		input logic done);
		cal_byte = 8'h00;
		cal_byte[CAL_EN_POS] = en;
		if (en) begin
			cal_byte[CAL_DONE_POS] = done;
			cal_byte[CAL_BYP_POS]  = bypass;
			cal_byte[CAL_DIFF_POS] = diff;
			cal_byte[CAL_RUN_POS]  = run;
		end
	endfunction

	always_comb begin
		logic [7:0] b;
		logic       start;
		b       = 8'h00;
		start   = 1'b0;
		next_st = st;
		rd      = RESET_WORD;
		src     = RESET_WORD;

		// External pin through a two-stage synchroniser
		next_st.ext_s1   = external_trigger_input_i;
		next_st.ext_s2   = st.ext_s1;
		next_st.sw_pulse = 1'b0;

		// Source vector indexed by selector code
		src[TRG_NONE]                = 1'b0;
		src[TRG_SW_COMMON]           = st.sw_pulse;
		src[TRG_SW_LEVEL]            = st.sw_level;
		src[TRG_RESERVED]            = 1'b0;
		src[TRG_PWM_SPECIAL]         = pwm_special_i;
		src[TRG_PWM_PRI1 +: 6]       = pwm_primary_i;
		src[TRG_LOGIC_ONE]           = logic_cell_one_output_i;
		src[TRG_TIMER1]              = timer1_period_i;
		src[TRG_TIMER2]              = timer2_period_i;
		src[TRG_SEC_SPECIAL]         = pwm_sec_special_i;
		src[TRG_PWM_SEC1 +: 6]       = pwm_secondary_i;
		src[TRG_LOGIC_TWO]           = logic_cell_two_output_i;
		src[TRG_OC1]                 = oc1_trigger_i;
		src[TRG_OC2]                 = oc2_trigger_i;
		src[TRG_PWM_CL1 +: 6]        = pwm_current_limit_i;
		src[TRG_PROG_GEN]            = programmable_trigger_generator_i;
		src[TRG_EXTERNAL]            = st.ext_s2;

		for (int t = 0; t < NUM_TRIG; t++) begin
			next_st.trig[t] = src[st.sel[t]];
		end

		// Classic bus: one wait state, ack for one cycle
		req         = wb_cyc_i && wb_stb_i && !st.ack;
		wr          = req && wb_we_i;
		addr        = {wb_adr_i[7:2], 2'b00};
		next_st.ack = req;

		// Read mux, unmapped addresses read zero
		for (int g = 0; g < NUM_GROUP; g++) begin
			if (addr == trig_off(g)) begin
				rd = {16'h0000, 3'b000, st.sel[2*g+1],
					3'b000, st.sel[2*g]};
			end
		end
		for (int k = 0; k < NUM_CORE; k++) begin
			if (addr == core_off(k)) begin
				rd[8*core_lane(k) +: 8] = cal_byte(st.en[k],
					st.bypass[k], st.diff[k], st.run[k],
					st.done[k]);
			end
		end
		if (addr == OFF_SWTRIG) begin
			rd[SW_LEVEL_POS] = st.sw_level;
		end
		if (addr == OFF_IRQ_STAT) begin
			rd[NUM_CORE-1:0] = st.irq_stat;
		end
		if (addr == OFF_IRQ_MASK) begin
			rd[NUM_CORE-1:0] = st.irq_mask;
		end
		if (req) begin
			next_st.rdata = rd;
		end

		// Trigger selector writes
		for (int g = 0; g < NUM_GROUP; g++) begin
			if (wr && addr == trig_off(g)) begin
				if (wb_sel_i[0]) begin
					next_st.sel[2*g] = wb_dat_i[4:0];
				end
				if (wb_sel_i[1]) begin
					next_st.sel[2*g+1] = wb_dat_i[12:8];
				end
			end
		end

		// Software triggers
		if (wr && addr == OFF_SWTRIG && wb_sel_i[0]) begin
			next_st.sw_pulse = wb_dat_i[SW_COMMON_POS];
			next_st.sw_level = wb_dat_i[SW_LEVEL_POS];
		end

		// Interrupt mask and write-one-to-clear status
		if (wr && addr == OFF_IRQ_MASK && wb_sel_i[0]) begin
			next_st.irq_mask = wb_dat_i[NUM_CORE-1:0];
		end
		if (wr && addr == OFF_IRQ_STAT && wb_sel_i[0]) begin
			next_st.irq_stat = st.irq_stat & ~wb_dat_i[NUM_CORE-1:0];
		end

		// Calibration sequencer per core
		for (int k = 0; k < NUM_CORE; k++) begin
			start = 1'b0;
			b     = 8'h00;
			if (wr && addr == core_off(k) && wb_sel_i[core_lane(k)]) begin
				b = wb_dat_i[8*core_lane(k) +: 8];
				next_st.en[k] = b[CAL_EN_POS];
				if (b[CAL_EN_POS]) begin
					next_st.bypass[k] = b[CAL_BYP_POS];
					next_st.diff[k]   = b[CAL_DIFF_POS];
					if (!st.powered[k]) begin
						next_st.powered[k] = 1'b1;
						start = !b[CAL_BYP_POS];
					end
					if (b[CAL_RUN_POS]) begin
						start = 1'b1;
					end
				end
			end
			if (st.run[k]) begin
				if (st.cnt[k] == CAL_LAST) begin
					next_st.run[k]      = 1'b0;
					next_st.done[k]     = 1'b1;
					next_st.irq_stat[k] = 1'b1;
				end else begin
					next_st.cnt[k] = st.cnt[k] + 6'h01;
				end
			end else if (start) begin
				next_st.run[k]  = 1'b1;
				next_st.done[k] = 1'b0;
				next_st.cnt[k]  = 6'h00;
			end
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st <= '0;
		end else if (ce_i) begin
			st <= next_st;
		end
	end

	assign wb_ack_o           = st.ack;
	assign wb_dat_o           = st.rdata;
	assign chan_trigger_o     = st.trig;
	assign cal_active_o       = st.run;
	assign cal_differential_o = st.diff;
	assign irq_o              = |(st.irq_stat & st.irq_mask);

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);

	sequence s_wr_core0;
		ce_i && wb_cyc_i && wb_stb_i && wb_we_i && !st.ack &&
			wb_adr_i[7:2] == OFF_CAL01[7:2] && wb_sel_i[0];
	endsequence

	sequence s_rd_addr(logic [7:0] a);
		st.ack && !wb_we_i && wb_adr_i[7:2] == a[7:2];
	endsequence

	sequence s_finish_core0;
		ce_i && st.run[0] && st.cnt[0] == CAL_LAST;
	endsequence

	a_ack_one_cycle: assert property (ce_i && st.ack |=> !st.ack)
		else $error("ack held longer than one cycle");

	a_ack_after_req: assert property (
		ce_i && wb_cyc_i && wb_stb_i && !st.ack |=> st.ack)
		else $error("request not answered next cycle");

	a_trig_none_idle: assert property (
		ce_i && st.sel[0] == TRG_NONE |=> !st.trig[0])
		else $error("no-trigger code fired a trigger");

	a_trig_reserved_quiet: assert property (
		ce_i && st.sel[1] == TRG_RESERVED |=> !st.trig[1])
		else $error("reserved code fired a trigger");

	a_trig_cl_last: assert property (
		ce_i && st.sel[0] == 5'(TRG_PWM_CL1 + 5'h05) &&
		pwm_current_limit_i[5] |=> st.trig[0])
		else $error("current-limit six not routed");

	a_trig_sec_first: assert property (
		ce_i && st.sel[0] == TRG_PWM_SEC1 &&
		!pwm_secondary_i[0] |=> !st.trig[0])
		else $error("secondary one routed wrongly");

	a_trig_ext_sync: assert property (
		ce_i && st.sel[0] == TRG_EXTERNAL && st.ext_s2 |=> st.trig[0])
		else $error("external trigger not routed");

	a_trig_oc_two: assert property (
		ce_i && st.sel[0] == TRG_OC2 && oc2_trigger_i |=> st.trig[0])
		else $error("output compare two not routed");

	a_trig_gap_zero: assert property (
		s_rd_addr(OFF_TRIG0) |-> st.rdata[7:5] == 3'b000 &&
		st.rdata[15:13] == 3'b000)
		else $error("unimplemented selector bits not zero");

	a_cal_gap_zero: assert property (
		s_rd_addr(OFF_CAL01) |-> st.rdata[6:4] == 3'b000 &&
		st.rdata[14:12] == 3'b000)
		else $error("calibration gap bits not zero");

	a_shr_low_zero: assert property (
		s_rd_addr(OFF_CAL_SHR) |-> st.rdata[7:0] == 8'h00)
		else $error("shared register low byte not zero");

	a_run_done_low: assert property (
		st.run[0] |-> !st.done[0])
		else $error("done high during calibration");

	a_done_on_finish: assert property (
		s_finish_core0 |=> !st.run[0] && st.done[0] && st.irq_stat[0])
		else $error("finish did not clear run and set done");

	a_start_runs: assert property (
		s_wr_core0 ##0 (wb_dat_i[CAL_EN_POS] && wb_dat_i[CAL_RUN_POS] &&
		!st.run[0]) |=> st.run[0] && st.cnt[0] == 6'h00)
		else $error("start bit did not launch calibration");

	a_gate_blocks: assert property (
		s_wr_core0 ##0 (!wb_dat_i[CAL_EN_POS] && !st.run[0])
		|=> !st.run[0] && !st.en[0])
		else $error("write with enable low took effect");

	a_bypass_skip: assert property (
		s_wr_core0 ##0 (!st.powered[0] && !st.run[0] &&
		wb_dat_i[CAL_EN_POS] && wb_dat_i[CAL_BYP_POS] &&
		!wb_dat_i[CAL_RUN_POS]) |=> !st.run[0])
		else $error("bypassed core was calibrated");

	a_done_hold: assert property (
		ce_i && !st.run[0] && !$past(st.run[0]) && st.done[0]
		|=> st.done[0] || st.run[0])
		else $error("done cleared without a new run");

	a_freeze_ce: assert property (!ce_i |=> $stable(st))
		else $error("state changed while clock enable low");

	a_sw_pulse_one: assert property (
		ce_i && st.sw_pulse |=> !st.sw_pulse)
		else $error("common software trigger longer than one cycle");

	a_level_trig: assert property (
		ce_i && st.sel[0] == TRG_SW_LEVEL && st.sw_level |=> st.trig[0])
		else $error("level software trigger not routed");

	a_pri_first: assert property (
		ce_i && st.sel[0] == TRG_PWM_PRI1 &&
		pwm_primary_i[0] |=> st.trig[0])
		else $error("primary one not routed");

	a_timer_two: assert property (
		ce_i && st.sel[0] == TRG_TIMER2 &&
		timer2_period_i |=> st.trig[0])
		else $error("timer two period match not routed");

	a_shr_done_set: assert property (
		ce_i && st.run[SHR_CORE] && st.cnt[SHR_CORE] == CAL_LAST
		|=> st.done[SHR_CORE] && !st.run[SHR_CORE])
		else $error("shared core completion not flagged");

	a_diff_gated: assert property (
		s_wr_core0 ##0 !wb_dat_i[CAL_EN_POS] |=> $stable(st.diff[0]))
		else $error("differential bit written with enable low");

	a_rd_gated: assert property (
		s_rd_addr(OFF_CAL01) ##0 !st.en[0] |-> st.rdata[7:0] == 8'h00)
		else $error("gated calibration bits read nonzero");

	a_irq_on_done: assert property (
		s_finish_core0 ##0 st.irq_mask[0] |=> irq_o)
		else $error("unmasked completion raised no interrupt");

endmodule
`default_nettype wire

// ===== logic/adc_ctl_pkg.sv
`default_nettype none
package adc_ctl_pkg;
	// Clock and calibration timing
	localparam int          CLK_MHZ     = 50;
	localparam int          CAL_TIME_NS = 1000;
	localparam int          CAL_CYCLES  = (CAL_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int          CAL_CNT_W   = 6;
	localparam logic [5:0]  CAL_LAST    = 6'(CAL_CYCLES - 1);

	// Sizes
	localparam int          NUM_CORE    = 5;
	localparam int          NUM_GROUP   = 6;
	localparam int          NUM_TRIG    = 12;
	localparam int          SEL_W       = 5;
	localparam int          SHR_CORE    = 4;

	// Register byte offsets
	localparam logic [7:0]  OFF_TRIG0    = 8'h00;
	localparam logic [7:0]  TRIG_STRIDE  = 8'h04;
	localparam logic [7:0]  OFF_CAL01    = 8'h18;
	localparam logic [7:0]  OFF_CAL23    = 8'h1C;
	localparam logic [7:0]  OFF_CAL_SHR  = 8'h20;
	localparam logic [7:0]  OFF_SWTRIG   = 8'h24;
	localparam logic [7:0]  OFF_IRQ_STAT = 8'h28;
	localparam logic [7:0]  OFF_IRQ_MASK = 8'h2C;
	localparam logic [31:0] RESET_WORD   = 32'h0000_0000;

	// Field positions
	localparam int          CAL_RUN_POS   = 0;
	localparam int          CAL_EN_POS    = 1;
	localparam int          CAL_DIFF_POS  = 2;
	localparam int          CAL_BYP_POS   = 3;
	localparam int          CAL_DONE_POS  = 7;
	localparam int          SW_COMMON_POS = 0;
	localparam int          SW_LEVEL_POS  = 1;

	// Trigger source codes
	localparam logic [4:0]  TRG_NONE        = 5'h00;
	localparam logic [4:0]  TRG_SW_COMMON   = 5'h01;
	localparam logic [4:0]  TRG_SW_LEVEL    = 5'h02;
	localparam logic [4:0]  TRG_RESERVED    = 5'h03;
	localparam logic [4:0]  TRG_PWM_SPECIAL = 5'h04;
	localparam logic [4:0]  TRG_PWM_PRI1    = 5'h05;
	localparam logic [4:0]  TRG_LOGIC_ONE   = 5'h0B;
	localparam logic [4:0]  TRG_TIMER1      = 5'h0C;
	localparam logic [4:0]  TRG_TIMER2      = 5'h0D;
	localparam logic [4:0]  TRG_SEC_SPECIAL = 5'h0E;
	localparam logic [4:0]  TRG_PWM_SEC1    = 5'h0F;
	localparam logic [4:0]  TRG_LOGIC_TWO   = 5'h15;
	localparam logic [4:0]  TRG_OC1         = 5'h16;
	localparam logic [4:0]  TRG_OC2         = 5'h17;
	localparam logic [4:0]  TRG_PWM_CL1     = 5'h18;
	localparam logic [4:0]  TRG_PROG_GEN    = 5'h1E;
	localparam logic [4:0]  TRG_EXTERNAL    = 5'h1F;
endpackage
`default_nettype wire

// ===== sim/trig_source_model.sv
`timescale 1ns/1ps
`default_nettype none
module trig_source_model (
	input  wire logic        clk_i,
	input  wire logic [31:0] fire_i,
	output logic             pwm_special_o,
	output logic [5:0]       pwm_primary_o,
	output logic             cell_one_o,
	output logic             timer1_o,
	output logic             timer2_o,
	output logic             sec_special_o,
	output logic [5:0]       pwm_secondary_o,
	output logic             cell_two_o,
	output logic             oc1_o,
	output logic             oc2_o,
	output logic [5:0]       current_limit_o,
	output logic             prog_gen_o,
	output logic             ext_pin_o
);
	// Bit k of fire_i, for k from 4 to 31, raises the source picked by code k
	always_ff @(posedge clk_i) begin
		pwm_special_o   <= fire_i[4];
		pwm_primary_o   <= fire_i[10:5];
		cell_one_o      <= fire_i[11];
		timer1_o        <= fire_i[12];
		timer2_o        <= fire_i[13];
		sec_special_o   <= fire_i[14];
		pwm_secondary_o <= fire_i[20:15];
		cell_two_o      <= fire_i[21];
		oc1_o           <= fire_i[22];
		oc2_o           <= fire_i[23];
		current_limit_o <= fire_i[29:24];
		prog_gen_o      <= fire_i[30];
		ext_pin_o       <= fire_i[31];
	end
endmodule
`default_nettype wire

// ===== sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin \
	checks++; \
	if ((gt) !== (ex)) begin \
		fails++; \
		$display("ERROR %s expected %h seen %h", nm, ex, gt); \
	end \
end
module testbench;
	import adc_ctl_pkg::*;
	logic             clk_i, resetn_i, cyc, stb, we, ce;
	logic [7:0]       adr;
	logic [3:0]       sel;
	logic [31:0]      dw, fire;
	wire logic [31:0] dr;
	wire logic        ack, irq, ps, l1, t1, t2, ss, l2, o1, o2, pg, ex;
	wire logic [5:0]  pp, sc, cl;
	wire logic [11:0] trg;
	wire logic [4:0]  act_o, dif;
	int               fails, checks, act[5];

	adc_trigger_cal u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
		.pwm_special_i(ps), .pwm_primary_i(pp),
		.logic_cell_one_output_i(l1), .timer1_period_i(t1),
		.timer2_period_i(t2), .pwm_sec_special_i(ss),
		.pwm_secondary_i(sc), .logic_cell_two_output_i(l2),
		.oc1_trigger_i(o1), .oc2_trigger_i(o2), .pwm_current_limit_i(cl),
		.programmable_trigger_generator_i(pg),
		.external_trigger_input_i(ex), .chan_trigger_o(trg),
		.cal_active_o(act_o), .cal_differential_o(dif), .irq_o(irq));

	trig_source_model u_src (.clk_i(clk_i), .fire_i(fire),
		.pwm_special_o(ps), .pwm_primary_o(pp), .cell_one_o(l1),
		.timer1_o(t1), .timer2_o(t2), .sec_special_o(ss),
		.pwm_secondary_o(sc), .cell_two_o(l2), .oc1_o(o1), .oc2_o(o2),
		.current_limit_o(cl), .prog_gen_o(pg), .ext_pin_o(ex));

	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	// Cycles each core spends calibrating
	always @(posedge clk_i) begin
		for (int k = 0; k < 5; k++) begin
			if (act_o[k] === 1'b1) act[k]++;
		end
	end

	task automatic results();
		if (fails == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	task automatic bus(input logic w, input logic [7:0] a,
			input logic [3:0] s, input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		dw <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		r = dr;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (ack !== 1'b1) begin
			fails++;
			results();
		end
		@(posedge clk_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [3:0] s,
			input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, s, d, r);
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		bus(1'b0, a, 4'hF, 32'h0, r);
		`CHK($sformatf("reg %h", a), e, r)
	endtask

	task automatic waitcal(input logic [4:0] m);
		int n;
		n = 0;
		while ((act_o & m) !== 5'h00 && n < 300) begin
			@(posedge clk_i);
			n++;
		end
		if (n == 300) begin
			fails++;
			results();
		end
	endtask

	task automatic regs_reset();
		for (int a = 0; a <= 'h2C; a += 4) rc(8'(a), 32'h0);
		rc(8'hFC, 32'h0);
		wr(8'h00, 4'h3, 32'hFFFF);
		rc(8'h00, 32'h1F1F);
		wr(8'h00, 4'h3, 32'h0);
	endtask

	task automatic trig_codes();
		int seen;
		for (int c = 0; c < 32; c++) begin
			wr(8'h00, 4'h1, 32'(c));
			if (c == 1) begin
				seen = 0;
				fork
					wr(8'h24, 4'h1, 32'h1);
					repeat (6) begin
						@(posedge clk_i);
						if (trg[0] === 1'b1) seen++;
					end
				join
				`CHK("common trigger", 1, seen)
			end else if (c == 2) begin
				wr(8'h24, 4'h1, 32'h2);
				repeat (3) @(posedge clk_i);
				`CHK("level trigger", 12'h001, trg)
				wr(8'h24, 4'h1, 32'h0);
			end else begin
				fire <= (c == 0 || c == 3) ? '1 : (32'h1 << c);
				repeat (5) @(posedge clk_i);
				`CHK($sformatf("code %0d", c), (c == 0 || c == 3) ? 12'h000 : 12'h001, trg)
				fire <= 32'h0;
				repeat (5) @(posedge clk_i);
				`CHK("trigger idle", 12'h000, trg)
			end
		end
		wr(8'h14, 4'h2, 32'h0C00);
		fire <= 32'h1000;
		repeat (5) @(posedge clk_i);
		`CHK("channel 11", 12'h800, trg)
		fire <= 32'h0;
		wr(8'h14, 4'h2, 32'h0);
		wr(8'h00, 4'h1, 32'h0);
	endtask

	task automatic core1_gate();
		wr(8'h18, 4'h2, 32'h0D00);
		rc(8'h18, 32'h0000);
		wr(8'h18, 4'h2, 32'h8E00);
		rc(8'h18, 32'h0E00);
		`CHK("diff mode", 5'h02, dif)
		`CHK("bypassed", 5'h00, act_o)
	endtask

	task automatic core0_cal();
		int a0;
		a0 = act[0];
		wr(8'h18, 4'h1, 32'h02);
		waitcal(5'h01);
		`CHK("power-up length", CAL_CYCLES, act[0] - a0)
		rc(8'h18, 32'h0E82);
		`CHK("irq masked", 1'b0, irq)
		wr(8'h2C, 4'h1, 32'h1);
		`CHK("irq unmasked", 1'b1, irq)
		a0 = act[0];
		wr(8'h18, 4'h1, 32'h03);
		rc(8'h18, 32'h0E03);
		ce <= 1'b0;
		repeat (10) @(posedge clk_i);
		`CHK("frozen run", 5'h01, act_o)
		ce <= 1'b1;
		waitcal(5'h01);
		`CHK("run length", CAL_CYCLES + 10, act[0] - a0)
		rc(8'h18, 32'h0E82);
		wr(8'h28, 4'h1, 32'h1);
		`CHK("irq cleared", 1'b0, irq)
		wr(8'h18, 4'h1, 32'h00);
		rc(8'h18, 32'h0E00);
	endtask

	task automatic cores_rest();
		wr(8'h1C, 4'h3, 32'h0702);
		wr(8'h20, 4'h2, 32'h0300);
		waitcal(5'h1C);
		rc(8'h1C, 32'h8682);
		rc(8'h20, 32'h8200);
		`CHK("diff modes", 5'h0A, dif)
		rc(8'h28, 32'h1C);
	endtask

	initial begin
		resetn_i = 1'b0;
		ce = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'h0;
		dw = 32'h0;
		fire = 32'h0;
		repeat (4) @(posedge clk_i);
		resetn_i <= 1'b1;
		@(posedge clk_i);
		regs_reset();
		trig_codes();
		core1_gate();
		core0_cal();
		cores_rest();
		results();
	end
endmodule
`default_nettype wire
